// >>> hdl/acl_top.sv
`timescale 1ns/1ns
`include "acl_params.svh"
module acl_top
  import acl_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = `ACL_ARG_TIMEOUT_CYC,
  parameter int          FIFO_WIDTH     = `ACL_FIFO_WIDTH,
  parameter int          FIFO_DEPTH     = `ACL_FIFO_DEPTH
) (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST,
  input  wire logic       I_RXD,
  output logic            O_TXD,
  input  wire logic       I_HOST_SEND_REQUEST,
  output logic            O_LINK_CLEAR_TO_SEND,
  input  wire logic       I_IRQ_EVENT,
  input  wire logic       I_IRQ_CLEAR,
  output logic            O_IRQ,
  output logic      [7:0] O_CMD_DATA,
  output logic            O_CMD_VALID,
  input  wire logic [7:0] I_TX_DATA,
  input  wire logic       I_TX_VALID,
  output logic            O_TX_READY,
  output logic            O_FE_BUSY,
  output logic      [1:0] O_FE_SCLK,
  output logic      [1:0] O_FE_SDO,
  output logic      [3:0] O_FE_CS_N,
  input  wire logic [3:0] I_FE_SDI
);
  typedef struct packed {
    acl_parse_t  p;
    logic [1:0]  chip;
    logic [7:0]  cnt;
    logic [31:0] tmo;
    logic [7:0]  sh;
    logic [7:0]  cap;
    logic [3:0]  phase;
    logic [2:0]  bitn;
    logic        ipend;
    logic [7:0]  ibyte;
    logic        link_rst;
    logic [7:0]  cmd_data;
    logic        cmd_valid;
    logic        irq;
    logic        brk_pend;
    logic        tx_busy;
    logic [11:0] tx_sh;
    logic [3:0]  tx_left;
    logic [15:0] tx_baud;
    logic        txd;
    logic [1:0]  sclk;
    logic [1:0]  sdo;
    logic [3:0]  cs_n;
  } acl_top_state_t;

  acl_top_state_t state_reg;
  acl_top_state_t state_next;
  logic           rx_valid;
  logic     [7:0] rx_data;
  logic           fifo_in_ready;
  logic           fifo_out_valid;
  logic     [7:0] fifo_out_data;
  logic           fifo_out_ready;
  logic           fe_active;
  logic           tx_allowed;
  logic           link_rst_any;

  function automatic acl_top_state_t idle_state();
    acl_top_state_t s;
    s      = '0;
    s.p    = P_IDLE;
    s.txd  = 1'b1;
    s.cs_n = 4'hf;
    return s;
  endfunction

  assign fe_active            = (state_reg.p != P_IDLE);
  assign tx_allowed           = I_HOST_SEND_REQUEST || fe_active;
  assign fifo_out_ready       = !state_reg.tx_busy && !state_reg.brk_pend && tx_allowed;
  assign link_rst_any         = I_RST || state_reg.link_rst;
  assign O_LINK_CLEAR_TO_SEND = I_HOST_SEND_REQUEST;
  assign O_TX_READY           = fifo_in_ready && !state_reg.ipend;
  assign O_TXD                = state_reg.txd;
  assign O_IRQ                = state_reg.irq;
  assign O_CMD_DATA           = state_reg.cmd_data;
  assign O_CMD_VALID          = state_reg.cmd_valid;
  assign O_FE_BUSY            = fe_active;
  assign O_FE_SCLK            = state_reg.sclk;
  assign O_FE_SDO             = state_reg.sdo;
  assign O_FE_CS_N            = state_reg.cs_n;

  acl_rx u_rx (
    .I_CLOCK (I_CLOCK),
    .i_rst   (link_rst_any),
    .i_rxd   (I_RXD),
    .o_valid (rx_valid),
    .o_data  (rx_data)
  );

  // Internal replies take the slot ahead of user bytes
  acl_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .I_CLOCK     (I_CLOCK),
    .i_rst       (link_rst_any),
    .i_in_valid  (state_reg.ipend || I_TX_VALID),
    .i_in_data   (state_reg.ipend ? state_reg.ibyte : I_TX_DATA),
    .o_in_ready  (fifo_in_ready),
    .o_out_valid (fifo_out_valid),
    .o_out_data  (fifo_out_data),
    .i_out_ready (fifo_out_ready)
  );

  always_comb begin
    state_next           = state_reg;
    state_next.link_rst  = 1'b0;
    state_next.cmd_valid = 1'b0;

    // Interrupt: one break per occurrence until cleared; set wins over clear
    if (I_IRQ_CLEAR) begin
      state_next.irq = 1'b0;
    end
    if (I_IRQ_EVENT && (!state_reg.irq || I_IRQ_CLEAR)) begin
      state_next.brk_pend = 1'b1;
    end

    if (state_reg.ipend && fifo_in_ready) begin
      state_next.ipend = 1'b0;
    end

    // Transmitter
    if (state_reg.tx_busy) begin
      if (state_reg.tx_baud == 16'(`ACL_BIT_CYCLES - 1)) begin
        state_next.tx_baud = '0;
        if (state_reg.tx_left == 4'h1) begin
          state_next.tx_busy = 1'b0;
          state_next.txd     = 1'b1;
        end else begin
          state_next.tx_sh   = {1'b0, state_reg.tx_sh[11:1]};
          state_next.txd     = state_reg.tx_sh[1];
          state_next.tx_left = state_reg.tx_left - 1'b1;
        end
      end else begin
        state_next.tx_baud = state_reg.tx_baud + 1'b1;
      end
    end else if (state_reg.brk_pend) begin
      state_next.tx_busy  = 1'b1;
      state_next.tx_sh    = '0;
      state_next.txd      = 1'b0;
      state_next.tx_left  = 4'(`ACL_BREAK_BITS);
      state_next.tx_baud  = '0;
      state_next.brk_pend = 1'b0;
      state_next.irq      = 1'b1;
    end else if (fifo_out_valid && tx_allowed) begin
      state_next.tx_busy = 1'b1;
      state_next.tx_sh   = {3'b011, fifo_out_data, 1'b0};
      state_next.txd     = 1'b0;
      state_next.tx_left = 4'(`ACL_FRAME_BITS);
      state_next.tx_baud = '0;
    end

    // Command parser and synchronous link
    case (state_reg.p)
      P_IDLE: begin
        if (rx_valid) begin
          if (rx_data == `ACL_CMD_LINK_RESET) begin
            state_next.link_rst = 1'b1;
          end else if (rx_data[7:2] == `ACL_CMD_FE_PROG_HI) begin
            state_next.p    = P_COUNT;
            state_next.chip = rx_data[1:0];
            state_next.tmo  = '0;
            state_next.cs_n = ~(4'h1 << rx_data[1:0]);
          end else begin
            state_next.cmd_data  = rx_data;
            state_next.cmd_valid = 1'b1;
          end
        end
      end
      P_COUNT, P_DATA: begin
        state_next.tmo = state_reg.tmo + 1'b1;
        if (rx_valid) begin
          state_next.tmo = '0;
          if (state_reg.p == P_COUNT) begin
            state_next.cnt = rx_data;
            state_next.p   = (rx_data == 8'h00) ? P_DONE : P_DATA;
          end else begin
            state_next.sh                    = rx_data;
            state_next.sdo[state_reg.chip[1]] = rx_data[7];
            state_next.phase                 = '0;
            state_next.bitn                  = '0;
            state_next.p                     = P_SHIFT;
          end
        end else if (state_reg.tmo == 32'(TIMEOUT_CYCLES - 1)) begin
          state_next.p = P_TOUT;
        end
      end
      P_SHIFT: begin
        state_next.phase = state_reg.phase + 1'b1;
        if (state_reg.phase == 4'(`ACL_SYNC_RISE_PHASE)) begin
          state_next.sclk[state_reg.chip[1]] = 1'b1;
          state_next.cap = {state_reg.cap[6:0], I_FE_SDI[state_reg.chip]};
        end
        if (state_reg.phase == 4'(`ACL_SYNC_LAST_PHASE)) begin
          state_next.sclk = '0;
          if (state_reg.bitn == 3'h7) begin
            state_next.p = P_PUSH;
          end else begin
            state_next.sh                    = {state_reg.sh[6:0], 1'b0};
            state_next.sdo[state_reg.chip[1]] = state_reg.sh[6];
            state_next.bitn                  = state_reg.bitn + 1'b1;
          end
        end
      end
      P_PUSH: begin
        if (!state_reg.ipend) begin
          state_next.ipend = 1'b1;
          state_next.ibyte = state_reg.cap;
          state_next.cnt   = state_reg.cnt - 1'b1;
          state_next.tmo   = '0;
          state_next.p     = (state_reg.cnt == 8'h01) ? P_DONE : P_DATA;
        end
      end
      P_TOUT: begin
        if (!state_reg.ipend) begin
          state_next.ipend = 1'b1;
          state_next.ibyte = `ACL_TIMEOUT_REPLY;
          state_next.p     = P_DONE;
        end
      end
      P_DONE: begin
        state_next.cs_n = 4'hf;
        state_next.sdo  = '0;
        state_next.sclk = '0;
        // Stay busy until the last reply has left the buffer, so it goes out without a request
        if (!state_reg.ipend && !fifo_out_valid) begin
          state_next.p = P_IDLE;
        end
      end
      default: begin
        state_next.p = P_IDLE;
      end
    endcase

    // Link reset clears everything but pending interrupt state
    if (state_reg.link_rst) begin
      state_next          = idle_state();
      state_next.irq      = state_reg.irq && !I_IRQ_CLEAR;
      state_next.brk_pend = state_reg.brk_pend || (I_IRQ_EVENT && (!state_reg.irq || I_IRQ_CLEAR));
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      state_reg <= idle_state();
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// >>> include/acl_params.svh
`ifndef ACL_PARAMS_SVH
`define ACL_PARAMS_SVH

// System clock and link timing
`define ACL_CLK_HZ            20000000
`define ACL_BAUD              57600
`define ACL_BIT_CYCLES        (`ACL_CLK_HZ / `ACL_BAUD)
`define ACL_HALF_CYCLES       (`ACL_BIT_CYCLES / 2)
`define ACL_ARG_TIMEOUT_US    1800
`define ACL_ARG_TIMEOUT_CYC   (`ACL_ARG_TIMEOUT_US * (`ACL_CLK_HZ / 1000000))

// Character framing, bit counts including start bit
`define ACL_FRAME_BITS        11
`define ACL_BREAK_BITS        12

// Synchronous link: clock divider 16, sclk high in upper half
`define ACL_SYNC_DIV          16
`define ACL_SYNC_RISE_PHASE   7
`define ACL_SYNC_LAST_PHASE   15

// Command and reply codes
`define ACL_CMD_LINK_RESET    8'hf0
`define ACL_CMD_FE_PROG_HI    6'h14
`define ACL_TIMEOUT_REPLY     8'hee

// Transmit buffer
`define ACL_FIFO_WIDTH        8
`define ACL_FIFO_DEPTH        8

`endif

// >>> include/acl_pkg.sv
package acl_pkg;

  typedef enum logic [2:0] {
    P_IDLE,
    P_COUNT,
    P_DATA,
    P_SHIFT,
    P_PUSH,
    P_TOUT,
    P_DONE
  } acl_parse_t;

  typedef enum logic [1:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP
  } acl_rx_state_t;

endpackage

// >>> hdl/acl_fifo.sv
`timescale 1ns/1ns
module acl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             I_CLOCK,
  input  wire logic             i_rst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic      [WIDTH-1:0] o_out_data,
  input  wire logic             i_out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wp;
    logic [AW-1:0]               rp;
    logic [AW:0]                 cnt;
  } acl_fifo_state_t;

  acl_fifo_state_t state_reg;
  acl_fifo_state_t state_next;
  logic            push;
  logic            pop;

  assign o_in_ready  = (state_reg.cnt != (AW+1)'(DEPTH));
  assign o_out_valid = (state_reg.cnt != '0);
  assign o_out_data  = state_reg.mem[state_reg.rp];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = i_out_ready && o_out_valid;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wp] = i_in_data;
      state_next.wp = (state_reg.wp == AW'(DEPTH - 1)) ? '0 : state_reg.wp + 1'b1;
    end
    if (pop) begin
      state_next.rp = (state_reg.rp == AW'(DEPTH - 1)) ? '0 : state_reg.rp + 1'b1;
    end
    case ({push, pop})
      2'b10:   state_next.cnt = state_reg.cnt + 1'b1;
      2'b01:   state_next.cnt = state_reg.cnt - 1'b1;
      default: state_next.cnt = state_reg.cnt;
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// >>> hdl/acl_rx.sv
`timescale 1ns/1ns
`include "acl_params.svh"
module acl_rx
  import acl_pkg::*;
(
  input  wire logic       I_CLOCK,
  input  wire logic       i_rst,
  input  wire logic       i_rxd,
  output logic            o_valid,
  output logic      [7:0] o_data
);
  typedef struct packed {
    acl_rx_state_t st;
    logic [15:0]   cnt;
    logic [2:0]    bitn;
    logic [7:0]    sh;
    logic [7:0]    data;
    logic          valid;
  } acl_rx_reg_t;

  acl_rx_reg_t state_reg;
  acl_rx_reg_t state_next;

  assign o_valid = state_reg.valid;
  assign o_data  = state_reg.data;

  always_comb begin
    state_next       = state_reg;
    state_next.valid = 1'b0;
    state_next.cnt   = state_reg.cnt + 1'b1;
    case (state_reg.st)
      RX_IDLE: begin
        state_next.cnt = '0;
        if (!i_rxd) begin
          state_next.st = RX_START;
        end
      end
      RX_START: begin
        if (state_reg.cnt == 16'(`ACL_HALF_CYCLES - 1)) begin
          state_next.cnt  = '0;
          state_next.bitn = '0;
          state_next.st   = i_rxd ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA: begin
        if (state_reg.cnt == 16'(`ACL_BIT_CYCLES - 1)) begin
          state_next.cnt  = '0;
          state_next.sh   = {i_rxd, state_reg.sh[7:1]};
          state_next.bitn = state_reg.bitn + 1'b1;
          if (state_reg.bitn == 3'h7) begin
            state_next.st = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (state_reg.cnt == 16'(`ACL_BIT_CYCLES - 1)) begin
          state_next.st = RX_IDLE;
          if (i_rxd) begin
            state_next.data  = state_reg.sh;
            state_next.valid = 1'b1;
          end
        end
      end
      default: begin
        state_next.st = RX_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLOCK) begin
    if (i_rst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
endmodule

// >>> testbench/acl_host_model.sv
`timescale 1ns/1ns
module acl_host_model (
  input  wire logic I_CLOCK,
  input  wire logic i_txd,
  output logic      o_rxd
);
  localparam int BIT = 347;
  logic [8:0]  got[$];
  logic [10:0] rx_frame;

  initial o_rxd = 1'b1;

  task automatic send_byte(input logic [7:0] b);
    logic [10:0] fr;
    fr = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      o_rxd = fr[i];
      repeat (BIT) @(posedge I_CLOCK);
      #1;
    end
  endtask

  // Bit 8 of each entry flags a break
  initial begin
    forever begin
      @(negedge i_txd);
      repeat (BIT / 2) @(posedge I_CLOCK);
      for (int i = 0; i < 11; i++) begin
        rx_frame[i] = i_txd;
        if (i < 10) repeat (BIT) @(posedge I_CLOCK);
      end
      got.push_back({rx_frame[10:9] == 2'b00, rx_frame[8:1]});
      if (i_txd !== 1'b1) @(posedge i_txd);
    end
  end
endmodule

// >>> testbench/acl_props.sv
`timescale 1ns/1ns
module acl_props (
  input  wire logic       I_CLOCK,
  input  wire logic       I_RST,
  input  wire logic       O_TXD,
  input  wire logic       I_HOST_SEND_REQUEST,
  input  wire logic       O_LINK_CLEAR_TO_SEND,
  input  wire logic       I_IRQ_CLEAR,
  input  wire logic       O_IRQ,
  input  wire logic       O_FE_BUSY,
  input  wire logic [1:0] O_FE_SCLK,
  input  wire logic [3:0] O_FE_CS_N
);
  logic [11:0] cnt;
  logic        txd_q;
  logic        irq_q;
  logic        brk;
  logic        fs;

  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RST);

  // Frame start and cycles left in the frame
  assign fs = txd_q && !O_TXD && cnt == 12'h000;

  always_ff @(posedge I_CLOCK) begin
    if (I_RST) begin
      cnt <= 12'h000;
      txd_q <= 1'b1;
      irq_q <= 1'b0;
      brk <= 1'b0;
    end else begin
      txd_q <= O_TXD;
      irq_q <= O_IRQ;
      if (fs) begin
        cnt <= 12'hee8;
        brk <= O_IRQ && !irq_q;
      end else if (cnt != 12'h000) begin
        cnt <= cnt - 12'h001;
      end
    end
  end

  property p_cts;
    O_LINK_CLEAR_TO_SEND == I_HOST_SEND_REQUEST;
  endproperty
  a_cts: assert property (p_cts) else $error("clear to send differs");

  property p_start_req;
    fs && !(O_IRQ && !irq_q) |-> $past(I_HOST_SEND_REQUEST) || $past(O_FE_BUSY);
  endproperty
  a_start_req: assert property (p_start_req) else $error("frame without request");

  property p_start_bit;
    cnt >= 12'hd8f |-> !O_TXD;
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("start bit short");

  property p_stop;
    cnt != 12'h000 && cnt <= 12'h2b6 && !brk |-> O_TXD;
  endproperty
  a_stop: assert property (p_stop) else $error("stop bits not high");

  property p_brk;
    brk && cnt != 12'h000 |-> !O_TXD;
  endproperty
  a_brk: assert property (p_brk) else $error("break bit high");

  property p_brk_tail;
    brk && cnt == 12'h001 |-> ##201 !O_TXD;
  endproperty
  a_brk_tail: assert property (p_brk_tail) else $error("break extra bit missing");

  property p_irq_brk;
    $rose(O_IRQ) |-> fs;
  endproperty
  a_irq_brk: assert property (p_irq_brk) else $error("irq without break start");

  property p_irq_hold;
    O_IRQ && !I_IRQ_CLEAR |=> O_IRQ;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");

  property p_cs_one;
    $countones(~O_FE_CS_N) <= 1;
  endproperty
  a_cs_one: assert property (p_cs_one) else $error("two chips selected");

  property p_sclk_sel;
    O_FE_SCLK != 2'b00 |-> O_FE_SCLK == {&O_FE_CS_N[1:0], &O_FE_CS_N[3:2]};
  endproperty
  a_sclk_sel: assert property (p_sclk_sel) else $error("shift clock wrong pair");

  property p_sclk_high;
    $rose(O_FE_SCLK[1]) |-> O_FE_SCLK[1] [*8] ##1 !O_FE_SCLK[1];
  endproperty
  a_sclk_high: assert property (p_sclk_high) else $error("shift clock phase");
endmodule

bind acl_top acl_props u_props (
  .I_CLOCK(I_CLOCK), .I_RST(I_RST), .O_TXD(O_TXD), .I_HOST_SEND_REQUEST(I_HOST_SEND_REQUEST),
  .O_LINK_CLEAR_TO_SEND(O_LINK_CLEAR_TO_SEND), .I_IRQ_CLEAR(I_IRQ_CLEAR), .O_IRQ(O_IRQ),
  .O_FE_BUSY(O_FE_BUSY), .O_FE_SCLK(O_FE_SCLK), .O_FE_CS_N(O_FE_CS_N)
);

// >>> testbench/tb.sv
`timescale 1ns/1ns
module tb;
  logic       clk, rst, req, irq_ev, irq_clr, tx_valid;
  logic [7:0] tx_data, cmd_data, sdo_cap, fe_sh;
  logic [3:0] fe_sdi, cs_n;
  logic       rxd, txd, cts, irq, cmd_valid, tx_ready, fe_busy;
  logic [1:0] sclk, sdo;
  logic [7:0] cmd_q[$];
  int         n_fail, samples_checked;

  acl_top #(.TIMEOUT_CYCLES(5000)) DUT (
    .I_CLOCK(clk), .I_RST(rst), .I_RXD(rxd), .O_TXD(txd), .I_HOST_SEND_REQUEST(req),
    .O_LINK_CLEAR_TO_SEND(cts), .I_IRQ_EVENT(irq_ev), .I_IRQ_CLEAR(irq_clr), .O_IRQ(irq),
    .O_CMD_DATA(cmd_data), .O_CMD_VALID(cmd_valid), .I_TX_DATA(tx_data), .I_TX_VALID(tx_valid),
    .O_TX_READY(tx_ready), .O_FE_BUSY(fe_busy), .O_FE_SCLK(sclk), .O_FE_SDO(sdo),
    .O_FE_CS_N(cs_n), .I_FE_SDI(fe_sdi)
  );
  acl_host_model HOST (.I_CLOCK(clk), .i_txd(txd), .o_rxd(rxd));

  always @(posedge clk) if (cmd_valid === 1'b1) cmd_q.push_back(cmd_data);
  always @(posedge sclk[1]) sdo_cap = {sdo_cap[6:0], sdo[1]};

  // Front-end status, MSB first; only chip 2 carries it, the others show the inverse
  assign fe_sdi = {~fe_sh[7], fe_sh[7], ~fe_sh[7], ~fe_sh[7]};
  always @(posedge sclk[1]) begin
    #1;
    fe_sh = {fe_sh[6:0], fe_sh[7]};
  end

  task automatic tally_and_finish;
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic hang;
    n_fail++;
    tally_and_finish;
  endtask

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic push(input logic [7:0] b);
    tx_data = b;
    tx_valid = 1'b1;
    for (int k = 0; k < 5000 && tx_ready !== 1'b1; k++) cyc(1);
    if (tx_ready !== 1'b1) hang();
    cyc(1);
    tx_valid = 1'b0;
    cyc(1);
  endtask

  task automatic wait_got(input int n);
    for (int k = 0; k < 40000 && HOST.got.size() < n; k++) cyc(1);
    if (HOST.got.size() < n) hang();
  endtask

  task automatic t_reset;
    check(txd, 1);
    check(cs_n, 9'h00f);
    check(irq, 0);
    check(sclk, 0);
  endtask

  task automatic t_buffer;
    for (int i = 0; i < 8; i++) push(8'(8'h10 + 8'h11 * i));
    cyc(800);
    check(tx_ready, 0);
    check(9'(HOST.got.size()), 0);
    check(cts, 0);
    req = 1'b1;
    cyc(1);
    check(cts, 1);
    wait_got(8);
    for (int i = 0; i < 8; i++) check(HOST.got[i], 9'(8'h10 + 8'h11 * i));
    req = 1'b0;
  endtask

  task automatic t_rx;
    cmd_q.delete();
    HOST.send_byte(8'h3c);
    HOST.send_byte(8'hc3);
    cyc(400);
    check(9'(cmd_q.size()), 2);
    check(cmd_q[0], 9'h03c);
    check(cmd_q[1], 9'h0c3);
  endtask

  task automatic t_break;
    HOST.got.delete();
    req = 1'b1;
    push(8'h5a);
    for (int k = 0; k < 100 && txd !== 1'b0; k++) cyc(1);
    cyc(500);
    irq_ev = 1'b1;
    cyc(1);
    irq_ev = 1'b0;
    cyc(1);
    check(irq, 0);
    wait_got(2);
    check(HOST.got[0], 9'h05a);
    check(HOST.got[1], 9'h100);
    check(irq, 1);
    irq_clr = 1'b1;
    cyc(1);
    irq_clr = 1'b0;
    cyc(1);
    check(irq, 0);
    req = 1'b0;
    cyc(600);
  endtask

  task automatic t_fe;
    HOST.got.delete();
    cmd_q.delete();
    sdo_cap = 8'h00;
    fe_sh = 8'h3c;
    req = 1'b0;
    HOST.send_byte(8'h52);
    HOST.send_byte(8'h01);
    check(cs_n, 9'h00b);
    check(fe_busy, 1);
    HOST.send_byte(8'ha5);
    wait_got(1);
    check(HOST.got[0], 9'h03c);
    check(sdo_cap, 9'h0a5);
    check(cs_n, 9'h00f);
    check(fe_busy, 0);
    check(9'(cmd_q.size()), 0);
  endtask

  task automatic t_timeout;
    HOST.got.delete();
    req = 1'b1;
    HOST.send_byte(8'h50);
    cyc(100);
    check(cs_n, 9'h00e);
    check(fe_busy, 1);
    wait_got(1);
    check(HOST.got[0], 9'h0ee);
    check(cs_n, 9'h00f);
    check(fe_busy, 0);
    req = 1'b0;
  endtask

  task automatic t_link_reset;
    HOST.got.delete();
    push(8'h77);
    HOST.send_byte(8'hf0);
    cyc(10);
    req = 1'b1;
    cyc(4000);
    check(9'(HOST.got.size()), 0);
    req = 1'b0;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  initial begin
    n_fail = 0;
    samples_checked = 0;
    rst = 1'b1;
    req = 1'b0;
    irq_ev = 1'b0;
    irq_clr = 1'b0;
    tx_valid = 1'b0;
    tx_data = 8'h00;
    fe_sh = 8'h00;
    sdo_cap = 8'h00;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    cyc(1);
    t_reset;
    t_buffer;
    t_rx;
    t_break;
    t_fe;
    t_timeout;
    t_link_reset;
    tally_and_finish;
  end
endmodule
